//--- logic/pus_pkg.sv
`default_nettype none
package pus_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int unsigned BUS_READY_US   = 3000;  // 3 ms bus_ready_time
  localparam int unsigned EN_HOLD_US     = 6500;  // 6.5 ms bulk stable
  localparam int unsigned MARGIN_US      = 5000;  // 5 ms completion margin
  localparam int unsigned DELAY_UNIT_US  = 1000;  // one step delay unit
  localparam int unsigned SOFT_START_US  = 1000;  // default rail soft start
  localparam int unsigned BUS_READY_CYC  = BUS_READY_US * CYC_PER_US;
  localparam int unsigned EN_HOLD_CYC    = EN_HOLD_US * CYC_PER_US;
  localparam int unsigned MARGIN_CYC     = MARGIN_US * CYC_PER_US;
  localparam int unsigned DELAY_UNIT_CYC = DELAY_UNIT_US * CYC_PER_US;
  localparam int unsigned SOFT_START_CYC = SOFT_START_US * CYC_PER_US;
  localparam int unsigned CNT_W          = 24;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_ENABLE  = 8'h32;
  localparam logic [7:0] REG_STEP0   = 8'h58;
  localparam logic [7:0] REG_STEP1   = 8'h59;
  localparam logic [7:0] REG_STEP2   = 8'h5A;
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned STAT_A_BIT = 5;
  localparam int unsigned STAT_B_BIT = 3;
  localparam int unsigned STAT_C_BIT = 2;
  localparam int unsigned STEP_RAIL_LSB = 0;  // [2:0] rails c,b,a
  localparam int unsigned STEP_DLY_LSB  = 3;  // [5:3] delay in units
  localparam logic [7:0] STEP0_RST   = 8'h09;
  localparam logic [7:0] STEP1_RST   = 8'h0A;
  localparam logic [7:0] STEP2_RST   = 8'h0C;
  localparam logic [7:0] STATUS_RST  = 8'h00;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_BOOT  = 3'b001,
    ST_IDLE  = 3'b010,
    ST_CHECK = 3'b011,
    ST_SOFT  = 3'b100,
    ST_DELAY = 3'b101,
    ST_DONE  = 3'b110
  } pus_state_type;

endpackage : pus_pkg
`default_nettype wire

//--- logic/pus_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pus_link_if;

  // ----------------------------------------------------------------
  // pins and management bus
  // ----------------------------------------------------------------
  logic       bulk_valid;   // bulk_input_supply above threshold
  logic       en_pin;       // regulator_enable_pin
  logic       pg_oe;        // supply_ok_output pull-down enable
  logic       pg_out;       // supply_ok_output driven value
  logic       mb_req;       // bus request pulse
  logic       mb_wr;        // write when high
  logic       mb_ccc;       // enable command code instead of access
  logic [7:0] mb_addr;      // register offset
  logic [7:0] mb_wdata;     // write data
  logic       mb_ack;       // answer pulse, accepted
  logic       mb_nack;      // answer pulse, refused
  logic [7:0] mb_rdata;     // read data, valid with mb_ack
  wire        pg_level;     // open-drain wire with pull-up

  // pull-up wins unless the device pulls
  assign pg_level = pg_oe ? pg_out : 1'b1;

  modport dev (
    input  bulk_valid, en_pin, mb_req, mb_wr, mb_ccc, mb_addr, mb_wdata,
    output pg_oe, pg_out, mb_ack, mb_nack, mb_rdata
  );

  modport host (
    output bulk_valid, en_pin, mb_req, mb_wr, mb_ccc, mb_addr, mb_wdata,
    input  pg_level, mb_ack, mb_nack, mb_rdata
  );

endinterface : pus_link_if
`default_nettype wire

//--- logic/pus_device_end.sv
// Function
// (RULE1) supply valid only above threshold; pin undriven before
// (RULE2) valid supply: pull power-good low, LDOs on
// (RULE3) power-good only pulled low or released
// (RULE4) bus usable within 3 ms of valid supply
// (RULE5) host waits bus ready before any access
// (RULE6) host waits 6.5 ms before enable request
// (RULE7) host keeps enable pin static, one rise only
// (RULE8) enable pin high starts rail turn-on
// (RULE9) bit 7 of 0x32 or command also enables
// (RULE10) check supply, then run steps 0 to 2
// (RULE11) on completion set status bits, release power-good
// (RULE12) host may read status after late power-good
// (RULE13) refuse bus accesses until completion time ends
// (RULE14) limit is soft start plus delays plus 5 ms
// (RULE15) steps in order, delay after each soft start
// (RULE16) delay starts after longest soft start of step
// (RULE17) step settings live at 0x58, 0x59, 0x5A
// (RULE18) count in clocks; supply loss returns to start
`timescale 1ns/1ns
`default_nettype none
module pus_device_end
  import pus_pkg::*;
#(
  parameter int unsigned BUS_CYC    = BUS_READY_CYC,
  parameter int unsigned MARGIN     = MARGIN_CYC,
  parameter int unsigned UNIT_CYC   = DELAY_UNIT_CYC,
  parameter int unsigned SS_A_CYC   = SOFT_START_CYC,
  parameter int unsigned SS_B_CYC   = SOFT_START_CYC,
  parameter int unsigned SS_C_CYC   = SOFT_START_CYC
)(
  input  wire logic  sys_clk,          // system clock
  input  wire logic  rst_n,            // synchronous reset, low active
  input  wire logic  clk_en,           // freezes all state when low
  pus_link_if.dev    link,             // pins and management bus
  output logic       aux_ldo_high_out, // high LDO enable
  output logic       aux_ldo_low_out,  // low LDO enable
  output logic       buck_rail_a,      // buck rail a enable
  output logic       buck_rail_b,      // buck rail b enable
  output logic       buck_rail_c,      // buck rail c enable
  output logic       bus_ready,        // management bus usable
  output logic       seq_done          // power-up sequence finished
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned SS_AB  = (SS_A_CYC > SS_B_CYC) ? SS_A_CYC
                                                         : SS_B_CYC;
  localparam int unsigned SS_MAX = (SS_AB > SS_C_CYC) ? SS_AB : SS_C_CYC;

  pus_state_type    state;
  logic [2:0]       bulk_sync;
  logic [2:0]       pin_sync;
  logic             bulk_ok;
  logic             pin_hi;
  logic             reg_en;
  logic [7:0]       status;
  logic [7:0]       step_cfg [0:2];
  logic [1:0]       step;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] win_cnt;
  logic             ans_ack;
  logic             ans_nack;
  logic [7:0]       ans_data;
  logic             pg_drive;
  logic             pg_zero;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bulk_sync <= 3'h0;
      pin_sync  <= 3'h0;
      bulk_ok   <= 1'b0;
      pin_hi    <= 1'b0;
    end else if (clk_en) begin
      bulk_sync <= {bulk_sync[1:0], link.bulk_valid};
      pin_sync  <= {pin_sync[1:0], link.en_pin};
      if (bulk_sync[2] == bulk_sync[1]) begin
        bulk_ok <= bulk_sync[1];  // RULE1
      end
      if (pin_sync[2] == pin_sync[1]) begin
        pin_hi <= pin_sync[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // step decode
  // ----------------------------------------------------------------
  // current step fields
  wire [7:0] cur_cfg  = step_cfg[step];
  wire [2:0] cur_rail = cur_cfg[STEP_RAIL_LSB +: 3];
  wire [2:0] cur_dly  = cur_cfg[STEP_DLY_LSB +: 3];

  // longest soft start among rails of this step
  wire [CNT_W-1:0] ss_a = cur_rail[0] ? CNT_W'(SS_A_CYC) : '0;
  wire [CNT_W-1:0] ss_b = cur_rail[1] ? CNT_W'(SS_B_CYC) : '0;
  wire [CNT_W-1:0] ss_c = cur_rail[2] ? CNT_W'(SS_C_CYC) : '0;
  wire [CNT_W-1:0] ss_ab   = (ss_a > ss_b) ? ss_a : ss_b;
  wire [CNT_W-1:0] step_ss = (ss_ab > ss_c) ? ss_ab : ss_c; // RULE16
  wire [CNT_W-1:0] step_dly = CNT_W'(cur_dly * UNIT_CYC);

  // delay of each step with a rail bit set, for the completion limit
  wire [CNT_W-1:0] lim_dly [0:2];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_lim
      assign lim_dly[gi] = (step_cfg[gi][STEP_RAIL_LSB +: 3] != 3'h0)
        ? CNT_W'(step_cfg[gi][STEP_DLY_LSB +: 3] * UNIT_CYC) : '0;
    end
  endgenerate

  // completion limit: longest soft start, delays of steps with rails, margin
  wire [CNT_W-1:0] limit = CNT_W'(SS_MAX) + lim_dly[0] + lim_dly[1]
                         + lim_dly[2] + CNT_W'(MARGIN); // RULE14

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire busy      = (win_cnt != '0);
  wire refuse    = !bus_ready || busy;                  // RULE13 RULE5
  wire take      = link.mb_req && !refuse;
  wire hit_stat  = (link.mb_addr == REG_STATUS);
  wire hit_en    = (link.mb_addr == REG_ENABLE);
  wire hit_s0    = (link.mb_addr == REG_STEP0);
  wire hit_s1    = (link.mb_addr == REG_STEP1);
  wire hit_s2    = (link.mb_addr == REG_STEP2);
  wire wr_take   = take && link.mb_wr && !link.mb_ccc;
  wire en_write  = wr_take && hit_en;
  wire ccc_take  = take && link.mb_ccc;
  wire [7:0] rd_mux = hit_stat ? status
                    : hit_en   ? {reg_en, 7'h00}
                    : hit_s0   ? step_cfg[0]
                    : hit_s1   ? step_cfg[1]
                    : hit_s2   ? step_cfg[2] : 8'h00;

  // enable request from pin level or bus bit
  wire en_req = pin_hi || reg_en;                       // RULE8 RULE9
  wire cnt_end = (cnt == '0);
  wire last_step = (step == 2'd2);

  // ----------------------------------------------------------------
  // bus registers and answers
  // ----------------------------------------------------------------
  // one answer pulse the cycle after each request
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ans_ack  <= 1'b0;
      ans_nack <= 1'b0;
      ans_data <= 8'h00;
    end else if (clk_en) begin
      ans_ack  <= take;
      ans_nack <= link.mb_req && refuse;
      ans_data <= (take && !link.mb_wr) ? rd_mux : 8'h00;
    end
  end

  // writable registers; supply loss drops the enable bit
  always_ff @(posedge sys_clk) begin
    if (!rst_n || (clk_en && !bulk_ok)) begin
      reg_en      <= 1'b0;
      step_cfg[0] <= STEP0_RST;                         // RULE17
      step_cfg[1] <= STEP1_RST;
      step_cfg[2] <= STEP2_RST;
    end else if (clk_en) begin
      if (en_write || ccc_take) begin
        reg_en <= link.mb_ccc | link.mb_wdata[ENABLE_BIT]; // RULE9
      end
      if (wr_take && hit_s0) begin
        step_cfg[0] <= link.mb_wdata;
      end
      if (wr_take && hit_s1) begin
        step_cfg[1] <= link.mb_wdata;
      end
      if (wr_take && hit_s2) begin
        step_cfg[2] <= link.mb_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // completion window
  // ----------------------------------------------------------------
  // loads on a registered request, runs down in clocks
  always_ff @(posedge sys_clk) begin
    if (!rst_n || (clk_en && !bulk_ok)) begin
      win_cnt <= '0;
    end else if (clk_en) begin
      if (state == ST_IDLE && en_req) begin
        win_cnt <= limit;                               // RULE14
      end else if (busy) begin
        win_cnt <= win_cnt - 1'b1;                      // RULE18
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // supply loss from any state goes back to the off state
  always_ff @(posedge sys_clk) begin
    if (!rst_n || (clk_en && !bulk_ok)) begin
      state     <= ST_OFF;                              // RULE18
      step      <= 2'd0;
      cnt       <= '0;
      bus_ready <= 1'b0;
      seq_done  <= 1'b0;
      status    <= STATUS_RST;
      {buck_rail_c, buck_rail_b, buck_rail_a} <= 3'h0;
    end else if (clk_en) begin
      unique case (state)
        ST_OFF: begin
          state <= ST_BOOT;
          cnt   <= CNT_W'(BUS_CYC - 1);
        end
        ST_BOOT: begin
          if (cnt_end) begin
            bus_ready <= 1'b1;                          // RULE4
            state     <= ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_IDLE: begin
          if (en_req) begin
            state <= ST_CHECK;
            step  <= 2'd0;
          end
        end
        ST_CHECK: begin
          // supply already known good here; start the current step
          state <= ST_SOFT;                             // RULE10
          cnt   <= step_ss;
          {buck_rail_c, buck_rail_b, buck_rail_a} <=
            {buck_rail_c, buck_rail_b, buck_rail_a} | cur_rail;
        end
        ST_SOFT: begin
          if (cnt_end) begin
            state <= ST_DELAY;                          // RULE15
            cnt   <= step_dly;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_DELAY: begin
          if (!cnt_end) begin
            cnt <= cnt - 1'b1;
          end else if (last_step) begin
            state    <= ST_DONE;                        // RULE11
            seq_done <= 1'b1;
            status[STAT_A_BIT] <= buck_rail_a;
            status[STAT_B_BIT] <= buck_rail_b;
            status[STAT_C_BIT] <= buck_rail_c;
          end else begin
            step  <= step + 2'd1;                       // RULE15
            state <= ST_CHECK;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // LDOs and power-good pin
  // ----------------------------------------------------------------
  // LDOs on with valid supply; pin pulled until the sequence ends
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aux_ldo_high_out <= 1'b0;
      aux_ldo_low_out  <= 1'b0;
      pg_drive         <= 1'b0;
      pg_zero          <= 1'b0;
    end else if (clk_en) begin
      aux_ldo_high_out <= bulk_ok;                      // RULE2
      aux_ldo_low_out  <= bulk_ok;
      pg_drive <= bulk_ok && !(state == ST_DONE);       // RULE1 RULE2
      pg_zero  <= 1'b0;                                 // RULE3
    end
  end

  assign link.pg_oe    = pg_drive;
  assign link.pg_out   = pg_zero;
  assign link.mb_ack   = ans_ack;
  assign link.mb_nack  = ans_nack;
  assign link.mb_rdata = ans_data;

endmodule : pus_device_end
`default_nettype wire

//--- logic/pus_host_end.sv
`timescale 1ns/1ns
`default_nettype none
module pus_host_end
  import pus_pkg::*;
#(
  parameter int unsigned BUS_CYC  = BUS_READY_CYC,
  parameter int unsigned HOLD_CYC = EN_HOLD_CYC
)(
  input  wire logic       sys_clk,     // system clock
  input  wire logic       rst_n,       // synchronous reset, low active
  input  wire logic       clk_en,      // freezes all state when low
  pus_link_if.host        link,        // pins and management bus
  input  wire logic       supply_on,   // platform applies bulk supply
  input  wire logic       pin_req,     // pulse: raise enable pin
  input  wire logic       usr_req,     // pulse: bus request
  input  wire logic       usr_wr,      // write when high
  input  wire logic       usr_ccc,     // enable command code
  input  wire logic [7:0] usr_addr,    // register offset
  input  wire logic [7:0] usr_wdata,   // write data
  output logic            usr_done,    // pulse: request finished
  output logic            usr_nack,    // with done: refused
  output logic [7:0]      usr_rdata,   // read data with done
  output logic            bus_allowed, // bus access time reached
  output logic            en_allowed,  // enable hold time reached
  output logic            pg_high     // power-good pin seen high
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] up_cnt;
  logic [2:0]       pg_sync;
  logic             supply;
  logic             pin;
  logic             pend;
  logic             req_q;
  logic             wr_q;
  logic             ccc_q;
  logic [7:0]       addr_q;
  logic [7:0]       wdata_q;

  // ----------------------------------------------------------------
  // request screening
  // ----------------------------------------------------------------
  // enabling accesses wait for the hold time as well
  wire is_enable = usr_ccc || (usr_wr && usr_addr == REG_ENABLE
                               && usr_wdata[ENABLE_BIT]);
  wire may_send  = bus_allowed && !pend                 // RULE5
                   && (!is_enable || en_allowed);       // RULE6
  wire send      = usr_req && may_send;
  wire answered  = link.mb_ack || link.mb_nack;

  // ----------------------------------------------------------------
  // supply, timers and enable pin
  // ----------------------------------------------------------------
  // pin rises once after the hold time and falls only with supply
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      supply      <= 1'b0;
      up_cnt      <= '0;
      bus_allowed <= 1'b0;
      en_allowed  <= 1'b0;
      pin         <= 1'b0;
    end else if (clk_en) begin
      supply <= supply_on;
      if (!supply) begin
        up_cnt      <= '0;
        bus_allowed <= 1'b0;
        en_allowed  <= 1'b0;
        pin         <= 1'b0;
      end else begin
        if (!en_allowed) begin
          up_cnt <= up_cnt + 1'b1;
        end
        bus_allowed <= bus_allowed || (up_cnt >= CNT_W'(BUS_CYC));
        en_allowed  <= en_allowed || (up_cnt >= CNT_W'(HOLD_CYC));
        if (pin_req && en_allowed) begin
          pin <= 1'b1;                                  // RULE6 RULE7
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  // one request outstanding; refused user requests end at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pend      <= 1'b0;
      req_q     <= 1'b0;
      wr_q      <= 1'b0;
      ccc_q     <= 1'b0;
      addr_q    <= 8'h00;
      wdata_q   <= 8'h00;
      usr_done  <= 1'b0;
      usr_nack  <= 1'b0;
      usr_rdata <= 8'h00;
    end else if (clk_en) begin
      req_q    <= send;
      usr_done <= (pend && answered) || (usr_req && !may_send);
      usr_nack <= (pend && link.mb_nack) || (usr_req && !may_send);
      if (send) begin
        pend    <= 1'b1;
        wr_q    <= usr_wr;
        ccc_q   <= usr_ccc;                             // RULE9
        addr_q  <= usr_addr;
        wdata_q <= usr_wdata;
      end else if (pend && answered) begin
        pend      <= 1'b0;
        usr_rdata <= link.mb_rdata;                     // RULE12
      end
    end
  end

  // ----------------------------------------------------------------
  // power-good sampling
  // ----------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pg_sync <= 3'h0;
      pg_high <= 1'b0;
    end else if (clk_en) begin
      pg_sync <= {pg_sync[1:0], link.pg_level};
      if (pg_sync[2] == pg_sync[1]) begin
        pg_high <= pg_sync[1];
      end
    end
  end

  assign link.bulk_valid = supply;
  assign link.en_pin     = pin;
  assign link.mb_req     = req_q;
  assign link.mb_wr      = wr_q;
  assign link.mb_ccc     = ccc_q;
  assign link.mb_addr    = addr_q;
  assign link.mb_wdata   = wdata_q;

endmodule : pus_host_end
`default_nettype wire

//--- verif/pus_link_chk.sv
`timescale 1ns/1ns
`default_nettype none
module pus_link_chk #(
  parameter int BUS_CYC  = 30, // bus ready count
  parameter int MARGIN   = 50, // completion margin
  parameter int UNIT_CYC = 10, // step delay unit
  parameter int SS_MAX   = 8   // longest soft start
)(
  input wire logic       sys_clk,    // clock
  input wire logic       rst_n,      // reset, low active
  input wire logic       bulk_valid, // supply valid
  input wire logic       en_pin,     // enable pin
  input wire logic       pg_oe,      // power-good pull
  input wire logic       pg_out,     // pulled value
  input wire logic       mb_req,     // bus request
  input wire logic       mb_wr,      // write
  input wire logic       mb_ccc,     // enable command
  input wire logic [7:0] mb_addr,    // offset
  input wire logic [7:0] mb_wdata,   // write data
  input wire logic       mb_ack,     // accepted
  input wire logic       mb_nack,    // refused
  input wire logic [7:0] mb_rdata    // read data
);
  // ------------------------------------------------------------
  // enable tracking
  // ------------------------------------------------------------
  localparam int LIM = 3 * (SS_MAX + 2) + 21 * UNIT_CYC + MARGIN + 10;
  logic        pend_en; // enabling request outstanding
  logic        en_seen; // enable requested this supply cycle
  logic [15:0] up_cnt;  // cycles of valid supply
  logic [15:0] en_cnt;  // cycles since enable
  wire en_req = mb_req && (mb_ccc || (mb_wr && mb_addr == 8'h32
                && mb_wdata[7]));

  // counters cleared on reset or supply loss
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !bulk_valid) begin
      pend_en <= 1'b0;
      en_seen <= 1'b0;
      up_cnt  <= 16'h0000;
      en_cnt  <= 16'h0000;
    end else begin
      pend_en <= en_req;
      en_seen <= en_seen || en_pin || (pend_en && mb_ack);
      up_cnt  <= (up_cnt == 16'hffff) ? up_cnt : up_cnt + 16'h0001;
      en_cnt  <= en_seen ? en_cnt + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_pg_float; !bulk_valid [*6] |-> !pg_oe; endproperty
  a_pg_float: assert property (p_pg_float)
    else $error("power-good pulled without supply");
  property p_pg_pull; $rose(bulk_valid) |-> ##[3:8] pg_oe; endproperty
  a_pg_pull: assert property (p_pg_pull)
    else $error("power-good not pulled after supply");
  property p_pg_low; pg_oe |-> !pg_out; endproperty
  a_pg_low: assert property (p_pg_low)
    else $error("power-good driven high");
  property p_ready;
    mb_req && !en_seen && int'(up_cnt) > BUS_CYC + 10 |=> mb_ack;
  endproperty
  a_ready: assert property (p_ready)
    else $error("bus not ready in time");
  property p_answer; mb_req |=> mb_ack != mb_nack; endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer missing or double");
  property p_window;
    mb_req && en_seen && en_cnt > 16'h0008 && int'(en_cnt) < MARGIN
      |=> mb_nack && mb_rdata == 8'h00;
  endproperty
  a_window: assert property (p_window)
    else $error("access accepted during power-up");
  property p_limit;
    $fell(pg_oe) && bulk_valid |-> en_seen && int'(en_cnt) <= LIM;
  endproperty
  a_limit: assert property (p_limit)
    else $error("power-good release late or unrequested");
  property p_hold; pg_oe && !en_seen && bulk_valid |=> pg_oe; endproperty
  a_hold: assert property (p_hold)
    else $error("power-good released without enable");
endmodule : pus_link_chk
`default_nettype wire

//--- verif/test_pmic_power_up_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_pmic_power_up_sequencer import pus_pkg::*;;
  localparam int BUS = 30, MRG = 50, UNIT = 10;
  logic       sys_clk = 1'b0, rst_n = 1'b0, supply_on = 1'b0;
  logic       pin_req = 1'b0, usr_req = 1'b0, usr_wr = 1'b0;
  logic       usr_ccc = 1'b0, nk, clk_en = 1'b1;
  logic [7:0] usr_addr = 8'h00, usr_wdata = 8'h00, usr_rdata, got;
  logic       usr_done, usr_nack, bus_allowed, en_allowed, pg_high;
  logic       ldo_h, ldo_l, rail_a, rail_b, rail_c, bus_ready, seq_done;
  int         fail_count = 0, n_compared = 0, cyc = 0;
  pus_link_if link ();
  pus_device_end #(.BUS_CYC(BUS), .MARGIN(MRG), .UNIT_CYC(UNIT),
    .SS_A_CYC(8), .SS_B_CYC(5), .SS_C_CYC(3)) pus_device_end_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .link(link),
    .aux_ldo_high_out(ldo_h), .aux_ldo_low_out(ldo_l),
    .buck_rail_a(rail_a), .buck_rail_b(rail_b), .buck_rail_c(rail_c),
    .bus_ready(bus_ready), .seq_done(seq_done));
  pus_host_end #(.BUS_CYC(BUS), .HOLD_CYC(65)) pus_host_end_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .link(link),
    .supply_on(supply_on), .pin_req(pin_req), .usr_req(usr_req),
    .usr_wr(usr_wr), .usr_ccc(usr_ccc), .usr_addr(usr_addr),
    .usr_wdata(usr_wdata), .usr_done(usr_done), .usr_nack(usr_nack),
    .usr_rdata(usr_rdata), .bus_allowed(bus_allowed),
    .en_allowed(en_allowed), .pg_high(pg_high));
  pus_link_chk #(.BUS_CYC(BUS), .MARGIN(MRG), .UNIT_CYC(UNIT),
    .SS_MAX(8)) pus_link_chk_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .bulk_valid(link.bulk_valid),
    .en_pin(link.en_pin), .pg_oe(link.pg_oe), .pg_out(link.pg_out),
    .mb_req(link.mb_req), .mb_wr(link.mb_wr), .mb_ccc(link.mb_ccc),
    .mb_addr(link.mb_addr), .mb_wdata(link.mb_wdata),
    .mb_ack(link.mb_ack), .mb_nack(link.mb_nack),
    .mb_rdata(link.mb_rdata));

  // ------------------------------------------------------------
  // clock, watchdog and helpers
  // ------------------------------------------------------------
  initial forever #50 sys_clk = ~sys_clk;

  // hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // one request, bounded wait
  task automatic xfer(input logic w, c, input logic [7:0] a, d);
    int n;
    n = 0;
    @(posedge sys_clk);
    usr_req   <= 1'b1;
    usr_wr    <= w;
    usr_ccc   <= c;
    usr_addr  <= a;
    usr_wdata <= d;
    do begin
      @(posedge sys_clk);
      usr_req <= 1'b0;
      #1;
      n++;
    end while (!usr_done && n < 10);
    chk(8'(usr_done), 8'h01);
    nk  = usr_nack;
    got = usr_rdata;
  endtask : xfer

  task automatic rd(input logic [7:0] a, e, input logic n);
    xfer(1'b0, 1'b0, a, 8'h00);
    chk(8'(nk), 8'(n));
    if (!n) chk(got, e);
  endtask : rd

  // read until accepted
  task automatic poll(input logic [7:0] a, e);
    int n;
    n = 0;
    do begin
      xfer(1'b0, 1'b0, a, 8'h00);
      n++;
    end while (nk && n < 400);
    chk(8'(nk), 8'h00);
    chk(got, e);
  endtask : poll

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // one power-up per enable: write, pin, command
  initial begin
    int n;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      @(posedge sys_clk);
      supply_on <= 1'b0;
      repeat (12) @(posedge sys_clk);
      #1;
      chk(8'(pg_high), 8'h01);
      @(posedge sys_clk);
      supply_on <= 1'b1;
      rd(REG_STATUS, 8'h00, 1'b1);
      n = 0;
      while (!en_allowed && n < 300) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      repeat (10) @(posedge sys_clk);
      #1;
      chk({pg_high, bus_ready, ldo_h, ldo_l, rail_c, rail_b, rail_a, seq_done},
          8'h70);
      rd(REG_ENABLE, 8'h00, 1'b0);
      rd(8'h40, 8'h00, 1'b0);
      rd(REG_STEP1, STEP1_RST, 1'b0);
      if (m == 0) begin
        xfer(1'b1, 1'b0, REG_STEP1, 8'h1a);
        rd(REG_STEP1, 8'h1a, 1'b0);
      end
      if (m == 1) begin
        @(posedge sys_clk);
        pin_req <= 1'b1;
        @(posedge sys_clk);
        pin_req <= 1'b0;
      end else begin
        xfer(m == 0, m == 2, REG_ENABLE, 8'h80);
      end
      repeat (8) @(posedge sys_clk);
      clk_en <= 1'b0;
      repeat (120) @(posedge sys_clk);
      clk_en <= 1'b1;
      rd(REG_STATUS, 8'h00, 1'b1);
      poll(REG_STATUS, 8'h2c);
      chk({pg_high, bus_ready, ldo_h, ldo_l, rail_c, rail_b, rail_a, seq_done},
          8'hff);
      $display("test %0d done", m);
    end
    print_verdict();
  end
endmodule : test_pmic_power_up_sequencer
`default_nettype wire
